// ==== logic/eeprom_link_top.sv ====
// two-wire serial eeprom slave: link decoder, 8192-byte array, page buffer
// assumes sample_clk runs free and is much faster than the serial clock;
// the programming timer runs on clk and is reached through toggles
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - answer only when straps equal select bits
// - data changes only with clock low
// - ignore the bus until a start
// - stop ends transaction, back to idle
// - two address bytes, top three bits ignored
// - byte write acks both addresses and data
// - programming starts only at the stop
// - silent on the bus while programming
// - pages are 32 aligned bytes
// - page write address wraps inside page
// - ack and advance after each data byte
// - excess page bytes overwrite earlier ones
// - no address ack while busy, ack after
// - write protect refuses data, no programming
// - direction bit one requests a read
// - counter holds last location plus one, wrapping inside the page after a write
// - ack read address, shift out byte
// - next byte for every master ack
// - read counter wraps over whole array
// - type nibble 1010, lsb is direction
// - receiver pulls data low on ninth clock
module eeprom_link_top
  import eeprom_pkg::*;
#(
  parameter int WR_CYCLES_P = WR_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sample_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic write_protect,
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  output logic sda_out,
  output logic sda_oe_n,
  output logic prog_busy
);

  // ==========================================================================
  // declarations
  logic lrst1_ff;
  logic lrst2_ff;
  logic link_rstn;
  bus_sample_t bus_s1_ff;
  bus_sample_t bus_s2_ff;
  bus_sample_t bus_d_ff;
  pin_sample_t pin_s1_ff;
  pin_sample_t pin_s2_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic ack_tgl;
  logic req_tgl_ff;
  link_state_t state_ff;
  link_state_t after_ack_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] shreg_ff;
  logic [7:0] tx_ff;
  logic [HI_USED_W-1:0] hi_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic wr_pend_ff;
  logic mack_ff;
  logic sda_oe_n_ff;
  logic [PAGE_W-1:0] cidx_ff;
  logic [PAGE_LAST:0] valid_ff;
  logic [7:0] mem [0:MEM_BYTES-1];
  logic [7:0] page_buf [0:PAGE_LAST];
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic busy_link;
  logic dev_match;
  logic rx_state;
  logic byte_done;
  logic wr_take;
  logic addr_load;
  logic tx_load;
  logic [7:0] rd_byte;
  logic [ADDR_W-PAGE_W-1:0] addr_page;
  logic [PAGE_W-1:0] addr_off;

  // ==========================================================================
  // address arithmetic
  // read side walks the whole array and wraps to zero
  function automatic logic [ADDR_W-1:0] next_lin_addr(input logic [ADDR_W-1:0] a);
    next_lin_addr = a + 13'h0001;
  endfunction

  // write side keeps the page bits and wraps the offset
  function automatic logic [ADDR_W-1:0] next_page_addr(input logic [ADDR_W-1:0] a);
    next_page_addr = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 5'h01};
  endfunction

  // ==========================================================================
  // link-domain reset: asserts at once, leaves on the sampling clock
  always_ff @(posedge sample_clk or negedge resetn) begin
    if (!resetn) begin
      lrst1_ff <= 1'h0;
      lrst2_ff <= 1'h0;
    end else begin
      lrst1_ff <= 1'h1;
      lrst2_ff <= lrst1_ff;
    end
  end

  assign link_rstn = lrst2_ff;

  // ==========================================================================
  // pin synchronisers; the third bus stage exists only for edge finding
  always_ff @(posedge sample_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      bus_s1_ff <= '1;
      bus_s2_ff <= '1;
      bus_d_ff <= '1;
    end else begin
      bus_s1_ff <= '{scl: scl_in, sda: sda_in};
      bus_s2_ff <= bus_s1_ff;
      bus_d_ff <= bus_s2_ff;
    end
  end

  // straps and write protect are slow levels but still come from pins
  always_ff @(posedge sample_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= '{wp: write_protect,
                     sel: {select_strap_bit2, select_strap_bit1, select_strap_bit0}};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // the end-of-cycle toggle from the timer domain
  always_ff @(posedge sample_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      ack_s1_ff <= 1'h0;
      ack_s2_ff <= 1'h0;
    end else begin
      ack_s1_ff <= ack_tgl;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  // ==========================================================================
  // line events; a data change with clock high is start or stop only
  assign scl_rise = bus_s2_ff.scl & ~bus_d_ff.scl;
  assign scl_fall = ~bus_s2_ff.scl & bus_d_ff.scl;
  assign start_det = bus_s2_ff.scl & bus_d_ff.scl & bus_d_ff.sda & ~bus_s2_ff.sda;
  assign stop_det = bus_s2_ff.scl & bus_d_ff.scl & ~bus_d_ff.sda & bus_s2_ff.sda;

  // busy from the stop until the timer echoes the request
  assign busy_link = req_tgl_ff ^ ack_s2_ff;

  // type nibble, strap bits, and no answer at all while programming
  assign dev_match = (shreg_ff[7:4] == DEV_TYPE)
                     && (shreg_ff[3:1] == pin_s2_ff.sel)
                     && !busy_link;

  assign rx_state = (state_ff == ST_DEVADDR) || (state_ff == ST_ADDR_HI)
                    || (state_ff == ST_ADDR_LO) || (state_ff == ST_WDATA);
  assign byte_done = scl_fall && (bitcnt_ff == BIT_RX_LAST);
  assign wr_take = (state_ff == ST_WDATA) && byte_done && !pin_s2_ff.wp;
  assign addr_load = (state_ff == ST_ADDR_LO) && byte_done;
  assign tx_load = scl_fall && (((state_ff == ST_ACK) && (after_ack_ff == ST_RDATA))
                                || ((state_ff == ST_MACK) && mack_ff));
  assign rd_byte = mem[addr_ff];
  assign addr_page = addr_ff[ADDR_W-1:PAGE_W];
  assign addr_off = addr_ff[PAGE_W-1:0];

  // ==========================================================================
  // link state machine; stop and start outrank whatever byte is under way
  always_ff @(posedge sample_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      state_ff <= ST_IDLE;
      after_ack_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shreg_ff <= 8'h00;
      tx_ff <= 8'h00;
      hi_ff <= '0;
      addr_ff <= ADDR_RESET;
      wr_pend_ff <= 1'h0;
      mack_ff <= 1'h0;
      sda_oe_n_ff <= 1'h1;
      req_tgl_ff <= 1'h0;
      cidx_ff <= '0;
    end else if (state_ff == ST_COMMIT) begin
      // page is copied into the array one byte per sampling cycle
      cidx_ff <= cidx_ff + 5'h01;
      if (cidx_ff == PAGE_LAST) begin
        state_ff <= ST_IDLE;
      end
    end else if (stop_det) begin
      sda_oe_n_ff <= 1'h1;
      if (wr_pend_ff) begin
        state_ff <= ST_COMMIT;
        req_tgl_ff <= ~req_tgl_ff;
        wr_pend_ff <= 1'h0;
        cidx_ff <= '0;
      end else begin
        state_ff <= ST_IDLE;
      end
    end else if (start_det) begin
      // a repeated start drops unfinished write data on purpose
      sda_oe_n_ff <= 1'h1;
      wr_pend_ff <= 1'h0;
      bitcnt_ff <= 4'h0;
      state_ff <= busy_link ? ST_IDLE : ST_DEVADDR;
    end else begin
      if (scl_rise && rx_state && (bitcnt_ff != BIT_RX_LAST)) begin
        shreg_ff <= {shreg_ff[6:0], bus_s2_ff.sda};
        bitcnt_ff <= bitcnt_ff + 4'h1;
      end
      unique case (state_ff)
        ST_IDLE: begin
        end
        ST_DEVADDR: begin
          if (byte_done) begin
            if (dev_match) begin
              sda_oe_n_ff <= 1'h0;
              state_ff <= ST_ACK;
              after_ack_ff <= shreg_ff[0] ? ST_RDATA : ST_ADDR_HI;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_ADDR_HI: begin
          if (byte_done) begin
            hi_ff <= shreg_ff[HI_USED_W-1:0];
            sda_oe_n_ff <= 1'h0;
            state_ff <= ST_ACK;
            after_ack_ff <= ST_ADDR_LO;
          end
        end
        ST_ADDR_LO: begin
          if (byte_done) begin
            addr_ff <= {hi_ff, shreg_ff};
            sda_oe_n_ff <= 1'h0;
            state_ff <= ST_ACK;
            after_ack_ff <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            if (pin_s2_ff.wp) begin
              state_ff <= ST_IDLE;
              wr_pend_ff <= 1'h0;
            end else begin
              addr_ff <= next_page_addr(addr_ff);
              wr_pend_ff <= 1'h1;
              sda_oe_n_ff <= 1'h0;
              state_ff <= ST_ACK;
              after_ack_ff <= ST_WDATA;
            end
          end
        end
        ST_ACK: begin
          // the ack is released on the falling edge that ends the ninth clock
          if (scl_fall) begin
            bitcnt_ff <= 4'h0;
            if (tx_load) begin
              tx_ff <= rd_byte;
              sda_oe_n_ff <= rd_byte[7];
              addr_ff <= next_lin_addr(addr_ff);
              state_ff <= ST_RDATA;
            end else begin
              sda_oe_n_ff <= 1'h1;
              state_ff <= after_ack_ff;
            end
          end
        end
        ST_RDATA: begin
          // bits move only after a falling clock, so data never moves with clock high
          if (scl_fall) begin
            if (bitcnt_ff == BIT_TX_LAST) begin
              sda_oe_n_ff <= 1'h1;
              bitcnt_ff <= 4'h0;
              state_ff <= ST_MACK;
            end else begin
              tx_ff <= {tx_ff[6:0], 1'h0};
              sda_oe_n_ff <= tx_ff[6];
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_ff <= ~bus_s2_ff.sda;
          end
          if (tx_load) begin
            tx_ff <= rd_byte;
            sda_oe_n_ff <= rd_byte[7];
            addr_ff <= next_lin_addr(addr_ff);
            state_ff <= ST_RDATA;
          end else if (scl_fall) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_COMMIT: begin
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // page buffer and array; the buffer slot follows the wrapped offset, so
  // bytes past the thirty-second replace the oldest ones
  always_ff @(posedge sample_clk) begin
    if (wr_take) begin
      page_buf[addr_off] <= shreg_ff;
    end
    if ((state_ff == ST_COMMIT) && valid_ff[cidx_ff]) begin
      mem[{addr_page, cidx_ff}] <= page_buf[cidx_ff];
    end
  end

  // only the slots touched in this write are copied into the array
  always_ff @(posedge sample_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      valid_ff <= '0;
    end else if (addr_load) begin
      valid_ff <= '0;
    end else if ((state_ff == ST_COMMIT) && (cidx_ff == PAGE_LAST)) begin
      valid_ff <= '0;
    end else if (wr_take) begin
      valid_ff[addr_off] <= 1'h1;
    end
  end

  // ==========================================================================
  // open-drain data pin and programming timer
  assign sda_out = 1'h0;          // the pin only ever pulls low
  assign sda_oe_n = sda_oe_n_ff;

  prog_timer #(
    .CYCLES(WR_CYCLES_P)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .req_tgl(req_tgl_ff),
    .ack_tgl(ack_tgl),
    .busy(prog_busy)
  );

  // ==========================================================================
  // checks on the link logic
  a_strap_mismatch: assert property (@(posedge sample_clk) disable iff (!link_rstn)
    (state_ff == ST_DEVADDR) && byte_done && (shreg_ff[3:1] != pin_s2_ff.sel)
    |=> (state_ff == ST_IDLE) && sda_oe_n_ff)
    else $error("answered a foreign strap address");

  a_start_accept: assert property (@(posedge sample_clk) disable iff (!link_rstn)
    start_det && !busy_link && (state_ff != ST_COMMIT)
    |=> (state_ff == ST_DEVADDR) && (bitcnt_ff == 4'h0) && sda_oe_n_ff)
    else $error("start not taken");

  a_stop_idle: assert property (@(posedge sample_clk) disable iff (!link_rstn)
    stop_det && !wr_pend_ff && (state_ff != ST_COMMIT) |=> (state_ff == ST_IDLE))
    else $error("stop did not end the transaction");

  a_stop_program: assert property (@(posedge sample_clk) disable iff (!link_rstn)
    stop_det && wr_pend_ff && (state_ff != ST_COMMIT)
    |=> (state_ff == ST_COMMIT) && (req_tgl_ff != $past(req_tgl_ff)))
    else $error("stop after data did not start programming");

  a_busy_silent: assert property (@(posedge sample_clk) disable iff (!link_rstn)
    busy_link && (state_ff == ST_IDLE) |=> (state_ff != ST_DEVADDR) && sda_oe_n_ff)
    else $error("bus answered while programming");

  a_page_wrap: assert property (@(posedge sample_clk) disable iff (!link_rstn)
    wr_take |=> (addr_page == $past(addr_page)) && (addr_off == $past(addr_off) + 5'h01))
    else $error("page write left its page");

  a_data_ack: assert property (@(posedge sample_clk) disable iff (!link_rstn)
    wr_take |=> (state_ff == ST_ACK) && !sda_oe_n_ff)
    else $error("data byte not acknowledged");

  a_wp_refuse: assert property (@(posedge sample_clk) disable iff (!link_rstn)
    (state_ff == ST_WDATA) && byte_done && pin_s2_ff.wp
    |=> (state_ff == ST_IDLE) && sda_oe_n_ff && !wr_pend_ff)
    else $error("protected write was accepted");

  a_read_wrap: assert property (@(posedge sample_clk) disable iff (!link_rstn)
    tx_load && (addr_ff == ADDR_LAST) |=> (addr_ff == ADDR_RESET))
    else $error("read counter did not wrap to zero");

endmodule

`default_nettype wire

// ==== pkg/eeprom_pkg.sv ====
// constants, types and state codes shared by the serial eeprom slave
// assumes a 40 MHz system clock and a free-running sampling clock at the link
`default_nettype none

package eeprom_pkg;

  // ==========================================================================
  // slave address and array layout
  localparam logic [3:0] DEV_TYPE = 4'hA;      // memory-type pattern 1-0-1-0
  localparam int ADDR_W = 13;                  // 8192 byte locations
  localparam int MEM_BYTES = 8192;
  localparam int PAGE_W = 5;                   // 32 bytes per page
  localparam int HI_USED_W = 5;                // used low bits of the high byte
  localparam logic [4:0] PAGE_LAST = 5'h1F;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 13'h1FFF;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;

  // ==========================================================================
  // bit counting on the serial link
  localparam logic [3:0] BIT_RX_LAST = 4'h8;   // eight bits taken, ack slot next
  localparam logic [3:0] BIT_TX_LAST = 4'h7;   // index of the last driven bit

  // ==========================================================================
  // self-timed programming cycle
  localparam int T_WR_MS = 6;                  // longest write cycle time, ms
  localparam int CLK_PERIOD_NS = 25;
  localparam int WR_CYCLES = (T_WR_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TMR_W = 18;

  // ==========================================================================
  // carriers and states
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_sample_t;

  typedef struct packed {
    logic wp;
    logic [2:0] sel;
  } pin_sample_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_MACK,
    ST_COMMIT
  } link_state_t;

endpackage

`default_nettype wire

// ==== logic/prog_timer.sv ====
// self-timed programming cycle timer on the system clock
// assumes the request toggle comes from the sampling-clock domain
`timescale 1ns/1ps
`default_nettype none

module prog_timer
  import eeprom_pkg::*;
#(
  parameter int CYCLES = WR_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_tgl,
  output logic ack_tgl,
  output logic busy
);

  logic req_s1_ff;
  logic req_s2_ff;
  logic req_s3_ff;
  logic busy_ff;
  logic ack_ff;
  logic [TMR_W-1:0] cnt_ff;
  logic req_event;

  // ==========================================================================
  // request crossing: two flops, then a third for the toggle compare
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_s1_ff <= 1'h0;
      req_s2_ff <= 1'h0;
      req_s3_ff <= 1'h0;
    end else begin
      req_s1_ff <= req_tgl;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
    end
  end

  assign req_event = req_s2_ff ^ req_s3_ff;

  // ==========================================================================
  // countdown; the ack toggle echoes the request only when the cycle is over
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'h0;
      ack_ff <= 1'h0;
      cnt_ff <= '0;
    end else if (req_event && !busy_ff) begin
      busy_ff <= 1'h1;
      cnt_ff <= TMR_W'(CYCLES - 1);
    end else if (busy_ff) begin
      if (cnt_ff == '0) begin
        busy_ff <= 1'h0;
        ack_ff <= req_s3_ff;
      end else begin
        cnt_ff <= cnt_ff - TMR_W'(1);
      end
    end
  end

  assign busy = busy_ff;
  assign ack_tgl = ack_ff;

  // busy must stand a while once the cycle starts
  a_busy_hold: assert property (@(posedge clk) disable iff (!resetn)
    $rose(busy_ff) |-> busy_ff [*8])
    else $error("programming busy dropped too early");

endmodule

`default_nettype wire

// ==== tb/i2c_master_model.sv ====
// behavioural two-wire bus master that drives the eeprom slave's link pins
// assumes an open-drain data wire with a pull-up, resolved by the bench
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  // ==========================================================================
  // bus phases
  // one quarter is 14 clk cycles, which keeps each clock phase above four link samples
  localparam int QTR = 14;

  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic q(input int n);
    repeat (n * QTR) @(negedge clk);
  endtask

  // start and repeated start: data falls while the clock is high
  task automatic start_c;
    pull = 1'b0;
    // a slave ack may still hold the wire for about three link samples after
    // the clock fell; raising the clock sooner would turn its release into a stop
    q(2);
    scl = 1'b1;
    q(2);
    pull = 1'b1;
    q(2);
    scl = 1'b0;
  endtask

  // stop: data rises while the clock is high, then the bus is left idle
  task automatic stop_c;
    pull = 1'b1;
    q(2);                        // clock low must span at least four link samples
    scl = 1'b1;
    q(2);
    pull = 1'b0;
    q(2);
  endtask

  // data changes only in the low phase; the sample is taken mid-high
  task automatic bit_x(input logic b, output logic r);
    q(1);
    pull = ~b;
    q(2);
    scl = 1'b1;
    q(1);
    r = sda;
    q(1);
    scl = 1'b0;
  endtask

  // the ninth bit releases the wire so the receiver can acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~mack, r);
  endtask
endmodule

`default_nettype wire

// ==== tb/two_wire_serial_eeprom_slave_tb_top.sv ====
// self-checking bench for the serial eeprom slave
// assumes the master model on the link and a pull-up on the data wire
`timescale 1ns/1ps
`default_nettype none

module two_wire_serial_eeprom_slave_tb_top;
  import eeprom_pkg::*;
  // a short write cycle keeps polling to a few address bytes
  localparam int WR_P = 2000;
  logic clk = 1'b0;
  logic sample_clk = 1'b0;
  logic resetn = 1'b0;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h5;
  logic scl, pull, sda_out, sda_oe_n, prog_busy;
  wire logic sda;
  int err_count = 0;
  int n_checks = 0;

  // ==========================================================================
  // clocks, wire and instances
  always #12.5 clk = ~clk;
  initial begin
    #37;
    forever #80 sample_clk = ~sample_clk;
  end
  // open drain: low when either party pulls, pull-up otherwise
  assign sda = (sda_oe_n | sda_out) & ~pull;

  i2c_master_model mst (.clk(clk), .sda(sda), .scl(scl), .pull(pull));

  eeprom_link_top #(.WR_CYCLES_P(WR_P)) DUT (
    .clk(clk), .resetn(resetn), .sample_clk(sample_clk), .scl_in(scl), .sda_in(sda),
    .write_protect(wp), .select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]),
    .select_strap_bit2(strap[2]), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .prog_busy(prog_busy));

  // ==========================================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // start, write-direction slave address and both array address bytes, all acked
  task automatic send_addr(input logic [7:0] hi, input logic [7:0] lo);
    logic a;
    mst.start_c();
    mst.wr_byte({DEV_TYPE, strap, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    mst.wr_byte(hi, a);
    chk({7'h00, a}, 8'h01);
    mst.wr_byte(lo, a);
    chk({7'h00, a}, 8'h01);
  endtask

  // start or repeated start with read direction, acked; the caller reads the bytes
  task automatic rd_open;
    logic a;
    mst.start_c();
    mst.wr_byte({DEV_TYPE, strap, 1'b1}, a);
    chk({7'h00, a}, 8'h01);
  endtask

  // first poll right after the stop must go unanswered, a later one within 20 must succeed
  task automatic poll_ready;
    logic a;
    int n;
    mst.start_c();
    mst.wr_byte({DEV_TYPE, strap, 1'b0}, a);
    chk({7'h00, a}, 8'h00);
    chk({7'h00, prog_busy}, 8'h01);
    n = 0;
    while (a !== 1'b1 && n < 20) begin
      mst.start_c();
      mst.wr_byte({DEV_TYPE, strap, 1'b0}, a);
      n++;
    end
    mst.stop_c();
    chk({7'h00, a}, 8'h01);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_select;
    logic [7:0] bad [5] = '{8'hA8, 8'hAE, 8'hA2, 8'hBA, 8'h2A};
    logic a;
    for (int i = 0; i < 5; i++) begin
      mst.start_c();
      mst.wr_byte(bad[i], a);
      chk({7'h00, a}, 8'h00);
      // a good address without a new start is still ignored
      mst.wr_byte({DEV_TYPE, strap, 1'b0}, a);
      chk({7'h00, a}, 8'h00);
      mst.stop_c();
    end
    strap = 3'h2;
    mst.start_c();
    mst.wr_byte(8'hA4, a);
    chk({7'h00, a}, 8'h01);
    mst.stop_c();
    strap = 3'h5;
  endtask

  task automatic t_byte_write;
    logic a;
    logic [7:0] d;
    send_addr(8'hE0, 8'h00);
    mst.wr_byte(8'h5A, a);
    chk({7'h00, a}, 8'h01);
    mst.stop_c();
    poll_ready();
    send_addr(8'h00, 8'h00);
    rd_open();
    mst.rd_byte(1'b0, d);
    chk(d, 8'h5A);
    mst.stop_c();
  endtask

  // 34 bytes from offset 30 of the top page: the last two overwrite the first two
  task automatic t_page;
    logic a;
    logic [7:0] d;
    send_addr(8'h1F, 8'hFE);
    for (int i = 0; i < 34; i++) begin
      mst.wr_byte(8'h80 + 8'(i), a);
      chk({7'h00, a}, 8'h01);
    end
    mst.stop_c();
    poll_ready();
    rd_open();
    mst.rd_byte(1'b0, d);
    chk(d, 8'h82);
    mst.stop_c();
    send_addr(8'h1F, 8'hFE);
    rd_open();
    mst.rd_byte(1'b1, d);
    chk(d, 8'hA0);
    mst.rd_byte(1'b1, d);
    chk(d, 8'hA1);
    mst.rd_byte(1'b0, d);
    chk(d, 8'h5A);
    mst.stop_c();
  endtask

  task automatic t_wp;
    logic a;
    logic [7:0] d;
    wp = 1'b1;
    send_addr(8'h00, 8'h00);
    mst.wr_byte(8'hFF, a);
    chk({7'h00, a}, 8'h00);
    mst.stop_c();
    repeat (400) @(negedge clk);
    chk({7'h00, prog_busy}, 8'h00);
    wp = 1'b0;
    send_addr(8'h00, 8'h00);
    rd_open();
    mst.rd_byte(1'b0, d);
    chk(d, 8'h5A);
    mst.stop_c();
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (60) @(negedge clk);
    t_select();
    t_byte_write();
    t_page();
    t_wp();
    report_and_stop();
  end

  // the run needs about 60000 cycles; a hang is cut well beyond that
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule

`default_nettype wire
